/* arxsm_host.sv */
/* host port model: TDM slots 0-31, I2S/LJ slots 0-15 per half, in frame order, random gaps; bench clock */
module arxsm_host (
	input wire logic clk_in, en_in, fmt_in,
	output logic valid_out = 1'b0,
	output logic right_out = 1'b0,
	output logic [4:0] num_out = 5'h00,
	output logic [31:0] data_out = 32'h0000_0000);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] k = 5'h00;
	always @(posedge clk_in) begin
		valid_out <= en_in && $urandom_range(3) != 0;
		num_out <= fmt_in ? {1'b0, k[3:0]} : k;
		right_out <= k[4];
		data_out <= $urandom;
		k <= k + 5'h01;
	end
endmodule // arxsm_host

/* arxsm_monitor.sv */
/* checker for the ch6/ch7 slot map; sees arxsm_top ports, bound below */
module arxsm_monitor import arxsm_pkg::*; #(parameter int DATA_W = 32) (
	input wire logic clk_in, rst_b_in, reg_wr_in, reg_rd_in, slot_valid_in,
	input wire logic slot_right_in, fmt_i2s_lj_in,
	input wire logic chan6_valid_out, chan7_valid_out,
	input wire arxsm_byte_t reg_addr_in, reg_wdata_in, reg_rdata_out,
	input wire arxsm_slot_t slot_num_in,
	input wire arxsm_src_e chan6_dest_out, chan7_dest_out,
	input wire logic [DATA_W-1:0] slot_data_in,
	input wire logic [DATA_W-1:0] chan6_data_out, chan7_data_out);
	timeunit 1ns;
	timeprecision 1ps;
	arxsm_byte_t c6, c7;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	always_ff @(posedge clk_in or negedge rst_b_in)
		if (!rst_b_in) {c6, c7} <= 16'h0506;
		else if (reg_wr_in && reg_addr_in == 8'h2d) c6 <= reg_wdata_in & 8'h7f;
		else if (reg_wr_in && reg_addr_in == 8'h2e) c7 <= reg_wdata_in & 8'h7f;
	logic h6, h7;
	function automatic logic hit(arxsm_byte_t c, logic v, f, r,
		arxsm_slot_t n);
		return v && c[6:5] != 2'h0
			&& (f ? !n[4] && c[4:0] == {r, n[3:0]} : c[4:0] == n);
	endfunction
	assign h6 = hit(c6, slot_valid_in, fmt_i2s_lj_in, slot_right_in,
		slot_num_in);
	assign h7 = hit(c7, slot_valid_in, fmt_i2s_lj_in, slot_right_in,
		slot_num_in);
	sequence s_hit6; h6; endsequence
	sequence s_hit7; h7; endsequence
	a_ch6_route: assert property (s_hit6 |=> chan6_valid_out
		&& chan6_data_out == $past(slot_data_in)
		&& chan6_dest_out == $past(c6[6:5])) else $error("ch6 misrouted");
	a_ch7_route: assert property (s_hit7 |=> chan7_valid_out
		&& chan7_data_out == $past(slot_data_in)
		&& chan7_dest_out == $past(c7[6:5])) else $error("ch7 misrouted");
	a_ch6_quiet: assert property (!h6 |=> !chan6_valid_out)
		else $error("ch6 stray word");
	a_ch7_quiet: assert property (!h7 |=> !chan7_valid_out)
		else $error("ch7 stray word");
	a_ch6_read: assert property (reg_rd_in && reg_addr_in == 8'h2d
		|=> reg_rdata_out == $past(c6)) else $error("ch6 read wrong");
	a_ch7_read: assert property (reg_rd_in && reg_addr_in == 8'h2e
		|=> reg_rdata_out == $past(c7)) else $error("ch7 read wrong");
endmodule // arxsm_monitor
bind arxsm_top arxsm_monitor #(.DATA_W(DATA_W)) mon_u (.*);

/* arxsm_pkg.sv */
/*
 * Types for the receive channel 6/7 slot map.
 * Assumes nothing beyond the constants header.
 */
package arxsm_pkg;
	// what a received channel feeds
	typedef enum logic [1:0] {
		ARXSM_SRC_OFF      = 2'h0,
		ARXSM_SRC_DAC      = 2'h1,
		ARXSM_SRC_ADC_LOOP = 2'h2,
		ARXSM_SRC_CASCADE  = 2'h3
	} arxsm_src_e;

	typedef logic [4:0] arxsm_slot_t;
	typedef logic [7:0] arxsm_byte_t;
endpackage

/* arxsm_regs.svh */
/*
 * Register offsets, field positions and reset values for the receive
 * channel 6/7 slot map. Assumes inclusion by bare name from the design
 * file.
 */
// Operation
// - channel 6 source: 0 off, 1 DAC6, 2 ADC2 loopback, 3 cascade 1
// - channel 7 source: 0 off, 1 DAC7, 2 ADC3 loopback, 3 cascade 2
// - slot N is TDM slot N; I2S/LJ 0-15 left, 16-31 right
// - channel 6 register resets to 0x05: disabled, slot 5
// - channel 7 register resets to 0x06: disabled, slot 6
`ifndef ARXSM_REGS_SVH
`define ARXSM_REGS_SVH

`define ARXSM_CH6_OFFSET   8'h2d
`define ARXSM_CH7_OFFSET   8'h2e
`define ARXSM_CH6_RESET    8'h05
`define ARXSM_CH7_RESET    8'h06
`define ARXSM_RSVD_BIT     7
`define ARXSM_SRC_MSB      6
`define ARXSM_SRC_LSB      5
`define ARXSM_SLOT_MSB     4
`define ARXSM_SLOT_LSB     0
`define ARXSM_HALF_BIT     4
`define ARXSM_CFG_WMASK    8'h7f

`endif

/* arxsm_top.sv */
/*
 * Receive-side slot map of channels 6 and 7 on the primary audio port:
 * two configuration registers pick a slot and a destination per channel.
 * Assumes the serial deserialiser and the control port sit on clk_in and
 * present one received slot per valid pulse.
 */
`include "arxsm_regs.svh"

module arxsm_top #(
	parameter int DATA_W = 32
) (
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                rst_b_in,
	// register port
	input  wire arxsm_pkg::arxsm_byte_t reg_addr_in,
	input  wire arxsm_pkg::arxsm_byte_t reg_wdata_in,
	input  wire logic                reg_wr_in,
	input  wire logic                reg_rd_in,
	output logic [7:0]               reg_rdata_out,
	// received slot stream
	input  wire logic                slot_valid_in,
	input  wire arxsm_pkg::arxsm_slot_t slot_num_in,
	input  wire logic                slot_right_in,
	input  wire logic                fmt_i2s_lj_in,
	input  wire logic [DATA_W-1:0]   slot_data_in,
	// channel 6 output
	output logic                     chan6_valid_out,
	output arxsm_pkg::arxsm_src_e    chan6_dest_out,
	output logic [DATA_W-1:0]        chan6_data_out,
	// channel 7 output
	output logic                     chan7_valid_out,
	output arxsm_pkg::arxsm_src_e    chan7_dest_out,
	output logic [DATA_W-1:0]        chan7_data_out
);
	import arxsm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [6:0] cfg6;
	logic [6:0] cfg7;
	logic [6:0] next_cfg6;
	logic [6:0] next_cfg7;
	logic [7:0] next_rdata;
	logic       wr6;
	logic       wr7;

	// true when a strobe addresses the given register offset
	function automatic logic reg_sel(input logic strobe,
		input arxsm_byte_t addr, input arxsm_byte_t offset);
		return strobe && (addr == offset);
	endfunction

	// stored field of a write: the reserved top bit never lands
	function automatic logic [6:0] cfg_field(input arxsm_byte_t wdata);
		arxsm_byte_t masked;
		masked = wdata & `ARXSM_CFG_WMASK;
		return masked[6:0];
	endfunction

	assign wr6 = reg_sel(reg_wr_in, reg_addr_in, `ARXSM_CH6_OFFSET);
	assign wr7 = reg_sel(reg_wr_in, reg_addr_in, `ARXSM_CH7_OFFSET);

	////////////////////////////////////////////////////////////////////////
	// register write path

	always_comb begin
		next_cfg6 = cfg6;
		if (wr6) begin
			next_cfg6 = cfg_field(reg_wdata_in);
		end
	end

	always_comb begin
		next_cfg7 = cfg7;
		if (wr7) begin
			next_cfg7 = cfg_field(reg_wdata_in);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cfg6 <= 7'(`ARXSM_CH6_RESET);
		end else begin
			cfg6 <= next_cfg6;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cfg7 <= 7'(`ARXSM_CH7_RESET);
		end else begin
			cfg7 <= next_cfg7;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read path

	// reads: reserved bit 7 is zero, unmapped offsets read zero
	always_comb begin
		next_rdata = reg_rdata_out;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`ARXSM_CH6_OFFSET: next_rdata = {1'b0, cfg6};
				`ARXSM_CH7_OFFSET: next_rdata = {1'b0, cfg7};
				default:           next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			reg_rdata_out <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slot matching

	// true when the incoming slot is the one the field selects
	function automatic logic slot_hit(input arxsm_slot_t sel,
		input arxsm_slot_t num, input logic right, input logic i2s_lj);
		logic hit;
		hit = 1'b0;
		if (i2s_lj) begin
			// upper bit picks the half, low four bits the slot in it
			hit = (num[`ARXSM_HALF_BIT] == 1'b0)
				&& (right == sel[`ARXSM_HALF_BIT])
				&& (num[3:0] == sel[3:0]);
		end else begin
			hit = (num == sel);
		end
		return hit;
	endfunction

	arxsm_src_e src6;
	arxsm_src_e src7;
	logic       hit6;
	logic       hit7;

	assign src6 = arxsm_src_e'(cfg6[`ARXSM_SRC_MSB:`ARXSM_SRC_LSB]);
	assign src7 = arxsm_src_e'(cfg7[`ARXSM_SRC_MSB:`ARXSM_SRC_LSB]);

	assign hit6 = slot_hit(cfg6[`ARXSM_SLOT_MSB:`ARXSM_SLOT_LSB],
		slot_num_in, slot_right_in, fmt_i2s_lj_in);
	assign hit7 = slot_hit(cfg7[`ARXSM_SLOT_MSB:`ARXSM_SLOT_LSB],
		slot_num_in, slot_right_in, fmt_i2s_lj_in);

	////////////////////////////////////////////////////////////////////////
	// routed outputs

	logic              route6;
	logic              route7;
	arxsm_src_e        next_dest6;
	arxsm_src_e        next_dest7;
	logic [DATA_W-1:0] next_data6;
	logic [DATA_W-1:0] next_data7;

	function automatic logic route_ok(input logic valid, input logic hit,
		input arxsm_src_e src);
		return valid && hit && (src != ARXSM_SRC_OFF);
	endfunction

	assign route6 = route_ok(slot_valid_in, hit6, src6);
	assign route7 = route_ok(slot_valid_in, hit7, src7);

	// destination and word hold until the next routed word
	always_comb begin
		next_dest6 = chan6_dest_out;
		next_data6 = chan6_data_out;
		if (route6) begin
			next_dest6 = src6;
			next_data6 = slot_data_in;
		end
	end

	always_comb begin
		next_dest7 = chan7_dest_out;
		next_data7 = chan7_data_out;
		if (route7) begin
			next_dest7 = src7;
			next_data7 = slot_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output registers

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			chan6_valid_out <= 1'b0;
			chan6_dest_out  <= ARXSM_SRC_OFF;
			chan6_data_out  <= '0;
		end else begin
			// one-cycle pulse per routed word
			chan6_valid_out <= route6;
			chan6_dest_out  <= next_dest6;
			chan6_data_out  <= next_data6;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			chan7_valid_out <= 1'b0;
			chan7_dest_out  <= ARXSM_SRC_OFF;
			chan7_data_out  <= '0;
		end else begin
			// one-cycle pulse per routed word
			chan7_valid_out <= route7;
			chan7_dest_out  <= next_dest7;
			chan7_data_out  <= next_data7;
		end
	end

endmodule // arxsm_top

/* testbench.sv */
/* bench for the ch6/ch7 slot map; host model feeds the slot stream */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import arxsm_pkg::*;
	logic clk_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0, en = 0;
	logic fmt_i2s_lj_in = 0, slot_valid_in, slot_right_in, e6 = 0, e7 = 0;
	logic chan6_valid_out, chan7_valid_out;
	arxsm_byte_t reg_addr_in = '0, reg_wdata_in = '0, c6 = 8'h05, c7 = 8'h06;
	logic [7:0] reg_rdata_out, x;
	arxsm_slot_t slot_num_in;
	logic [31:0] slot_data_in, chan6_data_out, chan7_data_out, d6 = '0, d7 = '0;
	arxsm_src_e chan6_dest_out, chan7_dest_out;
	logic [1:0] y6 = '0, y7 = '0;
	wire [34:0] o6 = {chan6_valid_out, chan6_dest_out, chan6_data_out};
	wire [34:0] o7 = {chan7_valid_out, chan7_dest_out, chan7_data_out};
	int miscompares = 0, n_checks = 0;
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
	always #20 clk_in = ~clk_in;
	arxsm_top dut_u (.*);
	arxsm_host host_u (.clk_in, .en_in(en), .fmt_in(fmt_i2s_lj_in),
		.valid_out(slot_valid_in), .right_out(slot_right_in),
		.num_out(slot_num_in), .data_out(slot_data_in));
	function automatic logic hit(arxsm_byte_t c);
		return slot_valid_in && c[6:5] != 2'h0 && (fmt_i2s_lj_in ?
			!slot_num_in[4] && c[4:0] == {slot_right_in, slot_num_in[3:0]}
			: c[4:0] == slot_num_in);
	endfunction
	always @(posedge clk_in) if (rst_b_in) begin
		e6 <= hit(c6);
		e7 <= hit(c7);
		if (hit(c6)) {y6, d6} <= {c6[6:5], slot_data_in};
		if (hit(c7)) {y7, d7} <= {c7[6:5], slot_data_in};
		if (reg_wr_in && reg_addr_in == 8'h2d) c6 <= reg_wdata_in & 8'h7f;
		if (reg_wr_in && reg_addr_in == 8'h2e) c7 <= reg_wdata_in & 8'h7f;
	end
	always @(negedge clk_in) if (rst_b_in) begin
		`CK(o6, {e6, y6, d6})
		`CK(o7, {e7, y7, d7})
	end
	task automatic wr(arxsm_byte_t a, d);
		@(posedge clk_in);
		{reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
		@(posedge clk_in);
		reg_wr_in <= 0;
	endtask
	task automatic rd(arxsm_byte_t a);
		@(posedge clk_in);
		{reg_addr_in, reg_rd_in} <= {a, 1'b1};
		@(negedge clk_in);
		x = a == 8'h2d ? c6 : a == 8'h2e ? c7 : 8'h00;
		@(posedge clk_in);
		reg_rd_in <= 0;
		@(negedge clk_in);
		`CK(reg_rdata_out, x)
	endtask
	task wrap_up;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		void'($urandom(91));
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1;
		wr(8'h2f, 8'h7f);
		rd(8'h2d);
		rd(8'h2e);
		rd(8'h3f);
		en <= 1;
		for (int i = 0; i < 64; i++) begin
			fmt_i2s_lj_in <= i[5];
			// reserved bit always written as zero
			wr(8'h2d, {1'b0, i[1:0], i[2] ? 5'($urandom) : {i[3], {4{i[4]}}}});
			wr(8'h2e, {1'b0, ~i[1:0], 5'($urandom)});
			rd(8'h2d);
			rd(8'h2e);
			repeat (40) @(posedge clk_in);
		end
		wrap_up;
	end
	initial begin
		#400000;
		miscompares++;
		wrap_up;
	end
endmodule // testbench
